// ===== logic/rss_core.sv
`timescale 1ns/1ns
// Functional notes
// RULE1: rotate right through carry: old carry to bit 7, bit 0 to carry.
// RULE2: destination select 0 writes accumulator, 1 writes the addressed register.
// RULE3: literal minus accumulator into accumulator; carry and nibble carry mean no borrow.
// RULE4: register minus accumulator; carry, nibble carry, zero updated.
// RULE5: register minus accumulator minus inverted carry; status updated.
// RULE6: nibble exchange swaps register halves; no status bit changes.
// RULE7: power-down clears timeout counter and prescaler, sets expiry, clears sleep bit.
// RULE8: after power-down the oscillator is halted, the core sleeps.
// RULE9: zero bit set when an updating arithmetic result is zero, else cleared.
module rss_core import rss_pkg::*; #(
  parameter int PRE_W = 8
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic [11:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [11:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic osc_run // main oscillator enable
);
  logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
  logic [11:0] waddr_r, waddr_nxt;
  logic [31:0] wdat_r, wdat_nxt;
  logic [3:0] wstb_r, wstb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt, wd, wcur;
  logic [7:0] acc_r, acc_nxt, tmo_r, tmo_nxt;
  logic [PRE_W-1:0] pre_r, pre_nxt;
  logic c_r, c_nxt, nib_ovf_r, nib_ovf_nxt, z_r, z_nxt, sleep_ent_r, sleep_ent_nxt, expiry_r, expiry_nxt;
  logic [7:0] mem [DATA_WORDS];
  logic mem_we, commit, exec, dest, cin, osc_r, osc_nxt;
  logic [6:0] mem_wa;
  logic [7:0] mem_wd, lit, f_val, a_op, res;
  logic [2:0] op;
  logic [8:0] sum9;
  logic [4:0] sum5;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[11:9] == OFF_DATA[11:9]) || a == OFF_INSTR || a == OFF_ACC ||
             a == OFF_STATUS || a == OFF_WAKE || a == OFF_TMO;
  endfunction

  function automatic logic [31:0] regread(input logic [11:0] a);
    regread = 32'h0000_0000;
    if (a[11:9] == OFF_DATA[11:9]) begin
      regread[7:0] = mem[a[8:2]];
    end else if (a == OFF_ACC) begin
      regread[7:0] = acc_r;
    end else if (a == OFF_STATUS) begin
      regread[5:0] = {!osc_r, expiry_r, sleep_ent_r, z_r, nib_ovf_r, c_r};
    end else if (a == OFF_TMO) begin
      regread[7:0] = tmo_r;
    end
  endfunction

  // bus side: address and data may arrive in either order, held until both are in
  always_comb begin
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    waddr_nxt = waddr_r;
    wdat_nxt = wdat_r;
    wstb_nxt = wstb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    commit = !awready_r && !wready_r && !bvalid_r;
    if (awvalid && awready_r) begin
      awready_nxt = 1'b0;
      waddr_nxt = {awaddr[11:2], 2'h0};
    end
    if (wvalid && wready_r) begin
      wready_nxt = 1'b0;
      wdat_nxt = wdata;
      wstb_nxt = wstrb;
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (commit) begin
      awready_nxt = 1'b1;
      wready_nxt = 1'b1;
      bvalid_nxt = 1'b1;
      bresp_nxt = mapped(waddr_r) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = regread({araddr[11:2], 2'h0});
      rresp_nxt = mapped({araddr[11:2], 2'h0}) ? RESP_OKAY : RESP_SLVERR;
    end
    arready_nxt = !rvalid_nxt;
  end

  // unstrobed lanes keep the register's present contents
  always_comb begin
    wcur = regread(waddr_r);
  end
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign wd[8*i +: 8] = wstb_r[i] ? wdat_r[8*i +: 8] : wcur[8*i +: 8];
  end

  assign op = wd[INS_OP_LSB +: 3];
  assign dest = wd[INS_DEST_BIT];
  assign lit = wd[INS_LIT_LSB +: 8];
  assign f_val = mem[wd[INS_ADDR_LSB +: 7]];
  assign a_op = (op == OP_SUBL) ? lit : f_val;
  assign cin = (op == OP_SUBB) ? c_r : 1'b1; // RULE5
  // a - w - borrow done as a + ~w + carry; carry out high means no borrow
  assign sum9 = {1'b0, a_op} + {1'b0, ~acc_r} + {8'h00, cin}; // RULE3 RULE4 RULE5
  assign sum5 = {1'b0, a_op[3:0]} + {1'b0, ~acc_r[3:0]} + {4'h0, cin}; // RULE3 RULE4

  // core datapath and power state
  always_comb begin
    acc_nxt = acc_r;
    c_nxt = c_r;
    nib_ovf_nxt = nib_ovf_r;
    z_nxt = z_r;
    sleep_ent_nxt = sleep_ent_r;
    expiry_nxt = expiry_r;
    osc_nxt = osc_r;
    pre_nxt = pre_r;
    tmo_nxt = tmo_r;
    mem_we = 1'b0;
    mem_wa = waddr_r[8:2];
    mem_wd = wd[7:0];
    exec = 1'b0;
    res = f_val;
    // timeout counter only advances while the oscillator runs
    if (osc_r) begin
      pre_nxt = pre_r + 1'b1;
      if (&pre_r) begin
        tmo_nxt = tmo_r + 8'h01;
      end
    end
    if (commit) begin
      if (waddr_r == OFF_INSTR) begin
        exec = osc_r; // no instruction runs while asleep
      end else if (waddr_r == OFF_ACC) begin
        acc_nxt = wd[7:0];
      end else if (waddr_r == OFF_STATUS) begin
        c_nxt = wd[ST_C];
        nib_ovf_nxt = wd[ST_NIB_OVF];
        z_nxt = wd[ST_Z];
      end else if (waddr_r == OFF_WAKE) begin
        osc_nxt = 1'b1;
      end else if (waddr_r[11:9] == OFF_DATA[11:9]) begin
        mem_we = 1'b1;
      end
    end
    if (exec) begin
      mem_wa = wd[INS_ADDR_LSB +: 7];
      case (op)
        OP_ROT: begin
          res = {c_r, f_val[7:1]}; // RULE1
          c_nxt = f_val[0]; // RULE1
        end
        OP_SUBL, OP_SUBF, OP_SUBB: begin
          res = sum9[7:0];
          c_nxt = sum9[8]; // RULE3 RULE4 RULE5
          nib_ovf_nxt = sum5[4]; // RULE3 RULE4 RULE5
          z_nxt = (sum9[7:0] == 8'h00); // RULE9
        end
        OP_SWAP: begin
          res = {f_val[3:0], f_val[7:4]}; // RULE6
        end
        OP_SLEEP: begin
          tmo_nxt = TMO_RST; // RULE7
          pre_nxt = '0; // RULE7
          expiry_nxt = 1'b1; // RULE7
          sleep_ent_nxt = 1'b0; // RULE7
          osc_nxt = 1'b0; // RULE8
        end
        default: begin
          res = f_val;
        end
      endcase
      if (op == OP_ROT || op == OP_SUBF || op == OP_SUBB || op == OP_SWAP) begin
        if (dest) begin // RULE2
          mem_we = 1'b1;
          mem_wd = res;
        end else begin
          acc_nxt = res; // RULE2
        end
      end else if (op == OP_SUBL) begin
        acc_nxt = res; // RULE3
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      arready_r <= 1'b1;
      waddr_r <= 12'h000;
      wdat_r <= 32'h0000_0000;
      wstb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      acc_r <= ACC_RST;
      c_r <= 1'b0;
      nib_ovf_r <= 1'b0;
      z_r <= 1'b0;
      sleep_ent_r <= SLEEP_ENT_RST;
      expiry_r <= EXPIRY_RST;
      osc_r <= 1'b1;
      pre_r <= '0;
      tmo_r <= TMO_RST;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      waddr_r <= waddr_nxt;
      wdat_r <= wdat_nxt;
      wstb_r <= wstb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      acc_r <= acc_nxt;
      c_r <= c_nxt;
      nib_ovf_r <= nib_ovf_nxt;
      z_r <= z_nxt;
      sleep_ent_r <= sleep_ent_nxt;
      expiry_r <= expiry_nxt;
      osc_r <= osc_nxt;
      pre_r <= pre_nxt;
      tmo_r <= tmo_nxt;
    end
  end

  // data file has no reset; software initialises what it uses
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign osc_run = osc_r;

  rot_carry_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
    exec && op == OP_ROT |=> c_r == $past(f_val[0]) && $stable({nib_ovf_r, z_r}))
    else $error("rotate carry wrong");
  dest_acc_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
    exec && !dest && (op == OP_ROT || op == OP_SWAP) |=> acc_r == $past(res))
    else $error("accumulator destination wrong");
  lit_sub_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
    exec && op == OP_SUBL |=> acc_r == $past(lit - acc_r) && c_r == $past(acc_r <= lit)
      && nib_ovf_r == $past(acc_r[3:0] <= lit[3:0]))
    else $error("literal subtract wrong");
  reg_sub_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
    exec && op == OP_SUBF |=> c_r == $past(acc_r <= f_val) && nib_ovf_r == $past(acc_r[3:0] <= f_val[3:0]))
    else $error("register subtract flags wrong");
  borrow_sub_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
    exec && op == OP_SUBB && !dest |=> acc_r == $past(f_val - acc_r - {7'h00, !c_r}))
    else $error("borrow subtract wrong");
  swap_flags_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
    exec && op == OP_SWAP |=> $stable({c_r, nib_ovf_r, z_r}) && ($stable(acc_r) || $past(!dest)))
    else $error("swap touched status");
  sleep_state_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
    exec && op == OP_SLEEP |=> tmo_r == TMO_RST && pre_r == '0 && expiry_r && !sleep_ent_r)
    else $error("power-down state wrong");
  osc_halt_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
    exec && op == OP_SLEEP |=> !osc_run ##1 (!osc_run || $past(commit && waddr_r == OFF_WAKE)))
    else $error("oscillator not halted");
  zero_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
    exec && (op == OP_SUBL || op == OP_SUBF || op == OP_SUBB) |=>
      z_r == ($past(a_op - acc_r - {7'h00, op == OP_SUBB && !c_r}) == 8'h00))
    else $error("zero flag wrong");
endmodule

// ===== logic/rss_pkg.sv
package rss_pkg;
  // register byte offsets on the AXI4-Lite slave
  localparam logic [11:0] OFF_INSTR = 12'h000;
  localparam logic [11:0] OFF_ACC = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_WAKE = 12'h00C;
  localparam logic [11:0] OFF_TMO = 12'h010;
  localparam logic [11:0] OFF_DATA = 12'h200;
  localparam int DATA_WORDS = 128;
  // instruction word fields
  localparam int INS_OP_LSB = 0;
  localparam int INS_DEST_BIT = 3;
  localparam int INS_LIT_LSB = 8;
  localparam int INS_ADDR_LSB = 16;
  // operation codes
  localparam logic [2:0] OP_ROT = 3'h0;
  localparam logic [2:0] OP_SUBL = 3'h1;
  localparam logic [2:0] OP_SUBF = 3'h2;
  localparam logic [2:0] OP_SUBB = 3'h3;
  localparam logic [2:0] OP_SWAP = 3'h4;
  localparam logic [2:0] OP_SLEEP = 3'h5;
  // status bit positions
  localparam int ST_C = 0;
  localparam int ST_NIB_OVF = 1;
  localparam int ST_Z = 2;
  localparam int ST_SLEEP_ENT = 3;
  localparam int ST_EXPIRY = 4;
  localparam int ST_ASLEEP = 5;
  // values after reset, and bus response codes
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] TMO_RST = 8'h00;
  localparam logic SLEEP_ENT_RST = 1'b1;
  localparam logic EXPIRY_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== test/rss_tb.sv
`timescale 1ns/1ns
module tb import rss_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, osc_run;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rv;
  int miscompares = 0;
  int n_compared = 0;
  // subtract cases: op, carry in, dest, f, w
  logic [27:0] tc [7] = '{28'h1000505, 28'h1010506, 28'h2011001, 28'h2008080,
    28'h3000505, 28'h3110505, 28'h31000FF};

  always #50 aclk = ~aclk;

  // short prescaler so the timeout counter moves within a few reads
  rss_core #(.PRE_W(2)) uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .osc_run(osc_run));

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  function automatic logic [31:0] ins(logic [2:0] o, logic d, logic [7:0] k, logic [6:0] a);
    return {9'h000, a, k, 4'h0, d, o};
  endfunction

  function automatic logic [11:0] da(int n);
    return OFF_DATA + 12'(4 * n);
  endfunction

  task t_reset;
    chk("osc_rst", 32'h1, {31'h0, osc_run});
    chk("rdy_rst", 32'h1C, {27'h0, awready, wready, arready, bvalid, rvalid});
    rd(OFF_STATUS);
    chk("status_rst", 32'h18, rv);
    rd(OFF_ACC);
    chk("acc_rst", 32'h0, rv);
    chk("acc_resp", {30'h0, RESP_OKAY}, {30'h0, resp});
  endtask

  task t_rot;
    wr(da(5), 32'h81);
    wr(OFF_STATUS, 32'h02);
    wr(OFF_INSTR, ins(OP_ROT, 1'b1, 8'h00, 7'd5));
    rd(da(5));
    chk("rot_f", 32'h40, rv);
    rd(OFF_STATUS);
    chk("rot_st", 32'h1B, rv);
    wr(OFF_INSTR, ins(OP_ROT, 1'b0, 8'h00, 7'd5));
    rd(OFF_ACC);
    chk("rot_w", 32'hA0, rv);
    rd(da(5));
    chk("rot_keep", 32'h40, rv);
    rd(OFF_STATUS);
    chk("rot_st2", 32'h1A, rv);
  endtask

  task t_sub;
    logic [2:0] o;
    logic c, d, dst, b;
    logic [7:0] f, w;
    logic [8:0] x;
    logic [4:0] n;
    for (int i = 0; i < 7; i++) begin
      {o, c, d, f, w} = {tc[i][26:24], tc[i][20], tc[i][16], tc[i][15:0]};
      wr(da(3), {24'h0, f});
      wr(OFF_ACC, {24'h0, w});
      wr(OFF_STATUS, {31'h0, c});
      wr(OFF_INSTR, ins(o, d, f, 7'd3));
      b = (o == OP_SUBB) ? !c : 1'b0;
      x = {1'b0, f} - {1'b0, w} - {8'h0, b};
      n = {1'b0, f[3:0]} - {1'b0, w[3:0]} - {4'h0, b};
      // literal form always lands in the accumulator
      dst = d && (o != OP_SUBL);
      rd(OFF_ACC);
      chk("sub_w", {24'h0, dst ? w : x[7:0]}, rv);
      rd(da(3));
      chk("sub_f", {24'h0, dst ? x[7:0] : f}, rv);
      rd(OFF_STATUS);
      chk("sub_st", 32'h18 | {29'h0, x[7:0] == 8'h0, ~n[4], ~x[8]}, rv);
    end
  endtask

  task t_swap;
    wr(da(9), 32'hA5);
    wr(OFF_STATUS, 32'h07);
    wr(OFF_INSTR, ins(OP_SWAP, 1'b1, 8'h00, 7'd9));
    rd(da(9));
    chk("swap_f", 32'h5A, rv);
    wr(OFF_INSTR, ins(OP_SWAP, 1'b0, 8'h00, 7'd9));
    rd(OFF_ACC);
    chk("swap_w", 32'hA5, rv);
    rd(OFF_STATUS);
    chk("swap_st", 32'h1F, rv);
  endtask

  task t_sleep;
    repeat (40) @(posedge aclk);
    rd(OFF_TMO);
    chk("tmo_run", 32'h1, {31'h0, rv != 32'h0});
    wr(OFF_ACC, 32'h11);
    wr(OFF_INSTR, ins(OP_SLEEP, 1'b0, 8'h00, 7'd0));
    chk("osc_off", 32'h0, {31'h0, osc_run});
    rd(OFF_TMO);
    chk("tmo_clr", 32'h0, rv);
    rd(OFF_STATUS);
    chk("sleep_st", 32'h37, rv);
    // a halted core must not execute anything
    wr(OFF_INSTR, ins(OP_SUBL, 1'b0, 8'h20, 7'd0));
    rd(OFF_ACC);
    chk("sleep_acc", 32'h11, rv);
    repeat (40) @(posedge aclk);
    rd(OFF_TMO);
    chk("tmo_frozen", 32'h0, rv);
    wr(OFF_WAKE, 32'h0);
    chk("osc_on", 32'h1, {31'h0, osc_run});
    // prescaler restarts from zero, so no count can have elapsed yet
    rd(OFF_TMO);
    chk("pre_clr", 32'h0, rv);
    rd(OFF_STATUS);
    chk("wake_st", 32'h17, rv);
  endtask

  task t_unmapped;
    wr(12'h100, 32'hFF);
    chk("bresp_err", {30'h0, RESP_SLVERR}, {30'h0, resp});
    rd(12'h100);
    chk("rresp_err", {30'h0, RESP_SLVERR}, {30'h0, resp});
    chk("rdata_err", 32'h0, rv);
    rd(OFF_INSTR);
    chk("instr_rd", 32'h0, rv);
  endtask

  task results;
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_rot;
    t_sub;
    t_swap;
    t_sleep;
    t_unmapped;
    results;
  end

  // whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    results;
  end
endmodule
